/* rtl/ifc_pkg.sv */
// Constants shared by the integer/float converter and its datapath core.
// Assumes byte addressing on a 32-bit Avalon-MM bus.
package ifc_pkg;
    // -------------------------------------------------------------------
    // Register byte addresses
    // -------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SRC_LO = 8'h04;
    localparam logic [7:0] ADDR_SRC_HI = 8'h08;
    localparam logic [7:0] ADDR_DST0 = 8'h0C;
    localparam logic [7:0] ADDR_DST1 = 8'h10;
    localparam logic [7:0] ADDR_DST2 = 8'h14;
    localparam logic [7:0] ADDR_DST3 = 8'h18;
    localparam logic [7:0] ADDR_FLAGS = 8'h1C;
    localparam logic [7:0] ADDR_ERRCODE = 8'h20;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
    // -------------------------------------------------------------------
    // Control fields, flag and interrupt bits
    // -------------------------------------------------------------------
    localparam int CTRL_W = 5;
    localparam int CTRL_PULSE = 3;
    localparam int CTRL_COND = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam int FLG_ZERO = 0;
    localparam int FLG_RND = 1;
    localparam int FLG_OVF = 2;
    localparam int FLG_ERR = 3;
    localparam int FLG_W = 4;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_RND = 1;
    localparam int IRQ_OVF = 2;
    localparam int IRQ_ERR = 3;
    localparam int IRQ_W = 4;
    localparam logic [15:0] ERR_FLOAT_RANGE = 16'h2013;
    // -------------------------------------------------------------------
    // Conversion select codes
    // -------------------------------------------------------------------
    localparam logic [2:0] OP_W2S = 3'h0;
    localparam logic [2:0] OP_D2S = 3'h1;
    localparam logic [2:0] OP_W2D = 3'h2;
    localparam logic [2:0] OP_D2D = 3'h3;
    localparam logic [2:0] OP_S2W = 3'h4;
    localparam logic [2:0] OP_S2D = 3'h5;
    // -------------------------------------------------------------------
    // Float encodings and integer limits
    // -------------------------------------------------------------------
    localparam logic [7:0] SGL_BIAS = 8'h7F;
    localparam logic [7:0] SGL_EXP_SPECIAL = 8'hFF;
    localparam logic [7:0] SGL_EXP_TOP = 8'hFE;
    localparam logic [7:0] SGL_EXP_I32 = 8'h9E;
    localparam logic [10:0] DBL_BIAS = 11'h3FF;
    localparam logic [10:0] DBL_EXP_TOP = 11'h7FE;
    localparam logic [31:0] SGL_MAX = 32'h7F7F_FFFF;
    localparam logic [31:0] SGL_MIN = 32'h0080_0000;
    localparam logic [63:0] DBL_MAX = 64'h7FEF_FFFF_FFFF_FFFF;
    localparam logic [63:0] DBL_MIN = 64'h0010_0000_0000_0000;
    localparam logic [32:0] WORD_POS_LIM = 33'h0_0000_7FFF;
    localparam logic [32:0] WORD_NEG_LIM = 33'h0_0000_8000;
    localparam logic [32:0] DWORD_POS_LIM = 33'h0_7FFF_FFFF;
    localparam logic [32:0] DWORD_NEG_LIM = 33'h0_8000_0000;
    localparam logic [15:0] WORD_MAX = 16'h7FFF;
    localparam logic [15:0] WORD_MIN = 16'h8000;
    localparam logic [31:0] DWORD_MAX = 32'h7FFF_FFFF;
    localparam logic [31:0] DWORD_MIN = 32'h8000_0000;
endpackage

/* rtl/ifc_conv_core.sv */
// Combinational conversion datapath: integer to single/double float,
// single float to 16/32-bit integer, with status outputs.
// Assumes the caller registers the result and flags.
`timescale 1ns/1ns
`default_nettype none
module ifc_conv_core (
    // Operation select
    input wire logic [2:0] opSel,
    // Source operand, low word in bits 15:0
    input wire logic [31:0] srcVal,
    // Result, low word in bits 15:0, and status
    output logic [63:0] result,
    output logic zeroOut,
    output logic roundOut,
    output logic ovfOut,
    output logic errOut
);
    logic wordSrc, neg, lost, fSign, fErr, fBig, fFrac, fOvf, dwordDst;
    logic [31:0] intIn, mag, norm, sres;
    logic [4:0] msb;
    logic [7:0] expS, fExp, fShift;
    logic [10:0] expD;
    logic [23:0] fMant;
    logic [63:0] wide, single, double, intRes;
    logic [32:0] fMag, limit;

    // Sign-extend word sources, take magnitude
    assign wordSrc = (opSel == ifc_pkg::OP_W2S) || (opSel == ifc_pkg::OP_W2D);
    assign intIn = wordSrc ? {{16{srcVal[15]}}, srcVal[15:0]} : srcVal;
    assign neg = intIn[31];
    assign mag = neg ? (32'h0000_0000 - intIn) : intIn;

    // Leading one position
    always_comb
    begin
        msb = 5'h00;
        for (int i = 0; i < 32; i++)
            if (mag[i])
                msb = 5'(i);
    end

    // Normalise and pack, truncating toward zero
    assign norm = mag << (5'h1F - msb);
    assign expS = ifc_pkg::SGL_BIAS + {3'h0, msb}; // RL17
    assign expD = ifc_pkg::DBL_BIAS + {6'h00, msb}; // RL17
    assign lost = |norm[7:0];
    assign single = {32'h0000_0000, neg, expS, norm[30:8]}; // RL1 RL2
    assign double = {neg, expD, norm[30:0], 21'h00_0000}; // RL3 RL4

    // Float source fields
    assign fSign = srcVal[31];
    assign fExp = srcVal[30:23];
    assign fMant = {fExp != 8'h00, srcVal[22:0]};
    assign fErr = fExp == ifc_pkg::SGL_EXP_SPECIAL; // RL16
    assign fBig = fExp > ifc_pkg::SGL_EXP_I32;
    assign fShift = fExp - ifc_pkg::SGL_BIAS;
    assign wide = {40'h00_0000_0000, fMant} << fShift[4:0];

    // Integer part and dropped fraction
    always_comb
    begin
        if (fExp < ifc_pkg::SGL_BIAS)
        begin
            fMag = 33'h0_0000_0000;
            fFrac = |srcVal[30:0]; // RL11
        end
        else
        begin
            fMag = wide[55:23]; // RL8
            fFrac = |wide[22:0]; // RL11
        end
    end

    // Range of the chosen destination width
    assign dwordDst = opSel == ifc_pkg::OP_S2D;
    assign limit = fSign
        ? (dwordDst ? ifc_pkg::DWORD_NEG_LIM : ifc_pkg::WORD_NEG_LIM)
        : (dwordDst ? ifc_pkg::DWORD_POS_LIM : ifc_pkg::WORD_POS_LIM);
    assign fOvf = fBig || (fMag > limit); // RL12 RL13 RL14
    assign sres = fSign ? (32'h0000_0000 - fMag[31:0]) : fMag[31:0];

    // Saturated integer result
    always_comb
    begin
        if (dwordDst)
            intRes = {32'h0000_0000, fOvf ? (fSign ? ifc_pkg::DWORD_MIN
                : ifc_pkg::DWORD_MAX) : sres}; // RL10
        else
            intRes = {48'h0000_0000_0000, fOvf ? (fSign ? ifc_pkg::WORD_MIN
                : ifc_pkg::WORD_MAX) : sres[15:0]}; // RL9
    end

    // Output selection with float range clamps
    always_comb
    begin
        result = 64'h0000_0000_0000_0000;
        roundOut = 1'b0;
        ovfOut = 1'b0;
        errOut = 1'b0;
        case (opSel)
            ifc_pkg::OP_W2S, ifc_pkg::OP_D2S:
            begin
                roundOut = lost; // RL6
                if (mag == 32'h0000_0000)
                    result = 64'h0000_0000_0000_0000;
                else if (expS > ifc_pkg::SGL_EXP_TOP)
                begin
                    ovfOut = 1'b1; // RL5
                    result = {32'h0000_0000, neg, ifc_pkg::SGL_MAX[30:0]};
                end
                else if (expS == 8'h00)
                begin
                    roundOut = 1'b1; // RL6
                    result = {32'h0000_0000, neg, ifc_pkg::SGL_MIN[30:0]};
                end
                else
                    result = single;
            end
            ifc_pkg::OP_W2D, ifc_pkg::OP_D2D:
            begin
                if (mag == 32'h0000_0000)
                    result = 64'h0000_0000_0000_0000;
                else if (expD > ifc_pkg::DBL_EXP_TOP)
                begin
                    ovfOut = 1'b1; // RL5
                    result = {neg, ifc_pkg::DBL_MAX[62:0]};
                end
                else if (expD == 11'h000)
                begin
                    roundOut = 1'b1; // RL6
                    result = {neg, ifc_pkg::DBL_MIN[62:0]};
                end
                else
                    result = double;
            end
            ifc_pkg::OP_S2W, ifc_pkg::OP_S2D:
            begin
                errOut = fErr;
                roundOut = fFrac;
                ovfOut = fOvf;
                result = intRes;
            end
            default:
                result = 64'h0000_0000_0000_0000;
        endcase
    end
    assign zeroOut = result == 64'h0000_0000_0000_0000; // RL7
endmodule
`default_nettype wire

/* rtl/ifc_converter.sv */
// Integer/float conversion block with Avalon-MM register access.
// Behaviour
// [RL1] Word integer to single float, result across two registers.
// [RL2] Doubleword integer to single float, two registers each side.
// [RL3] Word integer to double float, result across four registers.
// [RL4] Doubleword integer to double float, result across four registers.
// [RL5] Too-large float result: raise overflow, store largest float.
// [RL6] Too-small float result: raise underflow/rounding, store smallest.
// [RL7] Zero result raises the zero flag, every conversion.
// [RL8] Single float to integer drops the fractional part.
// [RL9] Single to word writes one register from a two-register source.
// [RL10] Single to doubleword writes two consecutive registers.
// [RL11] Discarded nonzero fraction raises underflow/rounding flag.
// [RL12] Result outside destination range raises overflow flag.
// [RL13] Word destination range is -32,768 to 32,767.
// [RL14] Doubleword range is -2,147,483,648 to 2,147,483,647.
// [RL15] Program must not pair 32-bit counters with word operands.
// [RL16] Out-of-range float source: skip, error flag, code 16#2013.
// [RL17] Floats are IEEE binary32/binary64; integers two's complement.
// [RL18] Low 16 bits sit in the lowest-numbered register.
// [RL19] Pulse mode runs once per rising condition; plain every cycle.
// Assumes one 20 MHz clock, synchronous reset, an Avalon-MM master.
`timescale 1ns/1ns
`default_nettype none
module ifc_converter (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Avalon-MM slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Interrupt
    output logic irq
);
    // -------------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------------
    logic [4:0] ctrlReg;
    logic [4:0] ctrlNext;
    logic [15:0] srcLoReg;
    logic [15:0] srcLoNext;
    logic [15:0] srcHiReg;
    logic [15:0] srcHiNext;
    logic [63:0] dstReg;
    logic [63:0] dstNext;
    logic [3:0] flagsReg;
    logic [3:0] flagsNext;
    logic [15:0] errCodeReg;
    logic [15:0] errCodeNext;
    logic [3:0] irqStatReg;
    logic [3:0] irqStatNext;
    logic [3:0] irqMaskReg;
    logic [3:0] irqMaskNext;
    logic condPrevReg;
    logic ackReg;
    logic [31:0] readdataReg;
    logic [31:0] rdMux;
    logic [31:0] beMask;
    logic [2:0] opSel;
    logic pulseMode;
    logic condNow;
    logic execNow;
    logic busReq;
    logic wrTake;
    logic rdLoad;
    logic selCtrl;
    logic selSrcLo;
    logic selSrcHi;
    logic selDst0;
    logic selDst1;
    logic selDst2;
    logic selDst3;
    logic selFlags;
    logic selErr;
    logic selStat;
    logic selMask;
    logic [63:0] coreResult;
    logic coreZero;
    logic coreRound;
    logic coreOvf;
    logic coreErr;
    logic [3:0] events;

    // -------------------------------------------------------------------
    // Bus handshake
    // -------------------------------------------------------------------

    // One wait state per access
    assign busReq = read | write;
    assign waitrequest = busReq & ~ackReg;
    assign wrTake = write & ackReg;
    assign rdLoad = read & ~ackReg;
    assign readdata = readdataReg;

    // Address decode
    assign selCtrl = address == ifc_pkg::ADDR_CTRL;
    assign selSrcLo = address == ifc_pkg::ADDR_SRC_LO;
    assign selSrcHi = address == ifc_pkg::ADDR_SRC_HI;
    assign selDst0 = address == ifc_pkg::ADDR_DST0;
    assign selDst1 = address == ifc_pkg::ADDR_DST1;
    assign selDst2 = address == ifc_pkg::ADDR_DST2;
    assign selDst3 = address == ifc_pkg::ADDR_DST3;
    assign selFlags = address == ifc_pkg::ADDR_FLAGS;
    assign selErr = address == ifc_pkg::ADDR_ERRCODE;
    assign selStat = address == ifc_pkg::ADDR_IRQ_STAT;
    assign selMask = address == ifc_pkg::ADDR_IRQ_MASK;

    // Byte lanes to bit mask
    assign beMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                     {8{byteenable[1]}}, {8{byteenable[0]}}};

    // Read selection, unmapped reads as zero
    assign rdMux =
        selCtrl ? {27'h000_0000, ctrlReg} :
        selSrcLo ? {16'h0000, srcLoReg} :
        selSrcHi ? {16'h0000, srcHiReg} :
        selDst0 ? {16'h0000, dstReg[15:0]} : // RL18
        selDst1 ? {16'h0000, dstReg[31:16]} :
        selDst2 ? {16'h0000, dstReg[47:32]} :
        selDst3 ? {16'h0000, dstReg[63:48]} :
        selFlags ? {28'h000_0000, flagsReg} :
        selErr ? {16'h0000, errCodeReg} :
        selStat ? {28'h000_0000, irqStatReg} :
        selMask ? {28'h000_0000, irqMaskReg} :
        32'h0000_0000;

    // Acknowledge and read data flops
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            ackReg <= 1'b0;
            readdataReg <= 32'h0000_0000;
        end
        else
        begin
            ackReg <= busReq & ~ackReg;
            if (rdLoad)
                readdataReg <= rdMux;
        end
    end

    // -------------------------------------------------------------------
    // Software-written registers
    // -------------------------------------------------------------------

    // Masked writes into control, source and mask
    assign ctrlNext = (wrTake && selCtrl)
        ? ((ctrlReg & ~beMask[4:0]) | (writedata[4:0] & beMask[4:0]))
        : ctrlReg;
    assign srcLoNext = (wrTake && selSrcLo)
        ? ((srcLoReg & ~beMask[15:0]) | (writedata[15:0] & beMask[15:0]))
        : srcLoReg;
    assign srcHiNext = (wrTake && selSrcHi)
        ? ((srcHiReg & ~beMask[15:0]) | (writedata[15:0] & beMask[15:0]))
        : srcHiReg;
    assign irqMaskNext = (wrTake && selMask)
        ? ((irqMaskReg & ~beMask[3:0]) | (writedata[3:0] & beMask[3:0]))
        : irqMaskReg;

    // Control field split
    assign opSel = ctrlReg[2:0];
    assign pulseMode = ctrlReg[ifc_pkg::CTRL_PULSE];
    assign condNow = ctrlReg[ifc_pkg::CTRL_COND];

    // Register update
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            ctrlReg <= ifc_pkg::CTRL_RESET;
            srcLoReg <= 16'h0000;
            srcHiReg <= 16'h0000;
            irqMaskReg <= 4'h0;
        end
        else
        begin
            ctrlReg <= ctrlNext;
            srcLoReg <= srcLoNext;
            srcHiReg <= srcHiNext;
            irqMaskReg <= irqMaskNext;
        end
    end

    // -------------------------------------------------------------------
    // Execution control
    // -------------------------------------------------------------------

    // Pulse mode fires on the rising condition only
    assign execNow = pulseMode ? (condNow & ~condPrevReg) : condNow; // RL19

    // Condition history
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            condPrevReg <= 1'b0;
        else
            condPrevReg <= condNow;
    end

    // -------------------------------------------------------------------
    // Datapath
    // -------------------------------------------------------------------

    // Conversion core, low register word in low bits
    ifc_conv_core u_core (
        .opSel(opSel),
        .srcVal({srcHiReg, srcLoReg}), // RL18
        .result(coreResult),
        .zeroOut(coreZero),
        .roundOut(coreRound),
        .ovfOut(coreOvf),
        .errOut(coreErr)
    );

    // Results and flags; an error leaves the destination untouched
    assign dstNext = (execNow && !coreErr) ? coreResult : dstReg; // RL16
    assign flagsNext = execNow
        ? {coreErr, coreOvf & ~coreErr, coreRound & ~coreErr,
           coreZero & ~coreErr} // RL7 RL11 RL12
        : flagsReg;
    assign errCodeNext = (execNow && coreErr)
        ? ifc_pkg::ERR_FLOAT_RANGE : errCodeReg; // RL16

    // Result register update
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            dstReg <= 64'h0000_0000_0000_0000;
            flagsReg <= 4'h0;
            errCodeReg <= 16'h0000;
        end
        else
        begin
            dstReg <= dstNext;
            flagsReg <= flagsNext;
            errCodeReg <= errCodeNext;
        end
    end

    // -------------------------------------------------------------------
    // Interrupts
    // -------------------------------------------------------------------

    // Events; set wins over write-one-to-clear
    assign events[ifc_pkg::IRQ_DONE] = execNow & ~coreErr;
    assign events[ifc_pkg::IRQ_RND] = execNow & ~coreErr & coreRound;
    assign events[ifc_pkg::IRQ_OVF] = execNow & ~coreErr & coreOvf;
    assign events[ifc_pkg::IRQ_ERR] = execNow & coreErr;
    assign irqStatNext = events | (irqStatReg &
        ~((wrTake && selStat) ? (writedata[3:0] & beMask[3:0]) : 4'h0));
    assign irq = |(irqStatReg & irqMaskReg);

    // Sticky status
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            irqStatReg <= 4'h0;
        else
            irqStatReg <= irqStatNext;
    end

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    // Zero flag follows the stored result
    a_zero_flag_match: assert property ( // RL7
        execNow && !coreErr |=> flagsReg[ifc_pkg::FLG_ZERO] ==
            (dstReg == 64'h0000_0000_0000_0000))
        else $error("zero flag disagrees with result");

    // Error skips the store and records the code
    a_err_skip_store: assert property ( // RL16
        execNow && coreErr |=> $stable(dstReg) &&
            errCodeReg == ifc_pkg::ERR_FLOAT_RANGE &&
            flagsReg[ifc_pkg::FLG_ERR])
        else $error("error conversion changed result");

    // Pulse mode runs once while the condition holds
    a_pulse_runs_once: assert property ( // RL19
        pulseMode && condNow && condPrevReg |-> !execNow)
        else $error("pulse conversion repeated");

    // Plain mode runs on every cycle of the condition
    a_plain_every_cycle: assert property ( // RL19
        !pulseMode && condNow |-> execNow)
        else $error("plain conversion skipped");

    // Word overflow saturates to the word limits
    a_word_sat_value: assert property ( // RL13
        execNow && !coreErr && coreOvf && opSel == ifc_pkg::OP_S2W
        |=> dstReg[15:0] == ($past(srcHiReg[15]) ? ifc_pkg::WORD_MIN
            : ifc_pkg::WORD_MAX) && dstReg[63:16] == 48'h0000_0000_0000)
        else $error("word saturation wrong");

    // Doubleword overflow saturates to the doubleword limits
    a_dword_sat_value: assert property ( // RL14
        execNow && !coreErr && coreOvf && opSel == ifc_pkg::OP_S2D
        |=> dstReg[31:0] == ($past(srcHiReg[15]) ? ifc_pkg::DWORD_MIN
            : ifc_pkg::DWORD_MAX))
        else $error("doubleword saturation wrong");

    // Word results keep the three upper registers clear
    a_word_upper_zero: assert property ( // RL9
        execNow &&
            !coreErr &&
            opSel == ifc_pkg::OP_S2W
        |=> dstReg[63:16] ==
            48'h0000_0000_0000)
        else $error("word result too wide");

    // Doubleword results keep the two upper registers clear
    a_dword_upper_zero: assert property ( // RL10
        execNow &&
            !coreErr &&
            opSel == ifc_pkg::OP_S2D
        |=> dstReg[63:32] ==
            32'h0000_0000)
        else $error("doubleword result too wide");

    // Single results fill only the two low registers
    a_single_two_words: assert property ( // RL1
        execNow && !coreErr && (opSel == ifc_pkg::OP_W2S ||
            opSel == ifc_pkg::OP_D2S)
        |=> dstReg[63:32] == 32'h0000_0000)
        else $error("single result beyond two registers");

    // Every access waits exactly one cycle
    a_bus_one_wait: assert property (
        $rose(busReq) |-> waitrequest ##1 !waitrequest)
        else $error("bus answer timing wrong");

    // Error event reaches the sticky status
    a_err_irq_set: assert property ( // RL16
        execNow && coreErr |=> irqStatReg[ifc_pkg::IRQ_ERR])
        else $error("error status not set");
endmodule
`default_nettype wire

/* tb/ifc_seq_model.sv */
// Sequencer model: Avalon-MM master that reaches the converter registers.
// Assumes the bench calls access only after reset and watches busHung.
`timescale 1ns/1ns
`default_nettype none
module ifc_seq_model (
    // Clock
    input wire logic sys_clk,
    // Avalon-MM master side
    output logic [7:0] address,
    output logic read,
    output logic write,
    output logic [3:0] byteenable,
    output logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Wait bound ran out
    output logic busHung
);
    // Idle bus at time zero
    initial
    begin
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        byteenable = 4'hF;
        writedata = 32'h0000_0000;
        busHung = 1'b0;
    end

    // One access; waits up to 20 cycles for waitrequest to drop
    task automatic access(input logic isWr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        address <= a;
        writedata <= d;
        write <= isWr;
        read <= !isWr;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 20);
        q = readdata;
        busHung <= (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the integer/float converter.
// Assumes the sequencer model drives the register bus.
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic sys_clk;
    logic reset;
    logic [7:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic waitrequest;
    logic irq;
    logic busHung;
    logic [31:0] q;
    logic [63:0] dst;
    int n_errors;
    int samples_checked;
    int seed;
    int r;
    int w;
    int d;

    ifc_converter ifc_converter_inst (.sys_clk(sys_clk), .reset(reset),
        .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .irq(irq));
    ifc_seq_model ifc_seq_model_inst (.sys_clk(sys_clk),
        .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .busHung(busHung));

    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    // 20 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic tally_and_finish();
        if (n_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // A hung bus wait counts as a mismatch
    always @(posedge sys_clk)
    begin
        if (busHung === 1'b1)
        begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        ifc_seq_model_inst.access(1'b1, a, v, q);
    endtask

    task automatic rd(input logic [7:0] a);
        ifc_seq_model_inst.access(1'b0, a, 32'h0000_0000, q);
    endtask

    // Expected binary64 and binary32 images of an integer
    function automatic logic [63:0] dbl(input int x);
        return $realtobits($itor(x));
    endfunction

    function automatic logic [31:0] sgl(input int x);
        logic [63:0] b;
        b = dbl(x);
        if (x == 0)
            return 32'h0000_0000;
        return {b[63], 8'(b[62:52] - 11'h380), b[51:29]};
    endfunction

    // One plain-mode conversion, then result and flag readback
    task automatic tcase(input logic [2:0] op, input logic [31:0] src,
        input logic [63:0] e, input logic [3:0] f);
        wr(ifc_pkg::ADDR_SRC_LO, {16'h0000, src[15:0]});
        wr(ifc_pkg::ADDR_SRC_HI, {16'h0000, src[31:16]});
        wr(ifc_pkg::ADDR_CTRL, {27'h000_0000, 2'b10, op});
        wr(ifc_pkg::ADDR_CTRL, 32'h0000_0000);
        for (int i = 0; i < 4; i++)
        begin
            rd(ifc_pkg::ADDR_DST0 + 8'(4 * i));
            dst[16 * i +: 16] = q[15:0];
        end
        check(dst, e);
        rd(ifc_pkg::ADDR_FLAGS);
        check(q, f);
    endtask

    // -------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------
    initial
    begin
        seed = 32'hdb77117f;
        n_errors = 0;
        samples_checked = 0;
        reset = 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        rd(ifc_pkg::ADDR_ERRCODE);
        check(q, 32'h0000_0000);
        // Hand-written corners
        tcase(ifc_pkg::OP_W2S, 32'h0000_000A, 64'h4120_0000, 4'h0);
        tcase(ifc_pkg::OP_D2S, 32'h0001_86A0, 64'h47C3_5000, 4'h0);
        tcase(ifc_pkg::OP_W2D, 32'h0000_000A,
            64'h4024_0000_0000_0000, 4'h0);
        tcase(ifc_pkg::OP_D2D, 32'h0001_86A0,
            64'h40F8_6A00_0000_0000, 4'h0);
        tcase(ifc_pkg::OP_D2D, 32'h0000_0000, 64'h0, 4'h1);
        tcase(ifc_pkg::OP_D2S, 32'h0100_0001, 64'h4B80_0000, 4'h2);
        tcase(ifc_pkg::OP_S2W, 32'h4020_0000, 64'h0002, 4'h2);
        tcase(ifc_pkg::OP_S2W, 32'hC020_0000, 64'hFFFE, 4'h2);
        tcase(ifc_pkg::OP_S2W, 32'h471C_4000, 64'h7FFF, 4'h4);
        tcase(ifc_pkg::OP_S2W, 32'hC700_0000, 64'h8000, 4'h0);
        tcase(ifc_pkg::OP_S2D, 32'h4F00_0000, 64'h7FFF_FFFF, 4'h4);
        tcase(ifc_pkg::OP_S2D, 32'hCF00_0000, 64'h8000_0000, 4'h0);
        tcase(ifc_pkg::OP_S2W, 32'h7F80_0000, 64'h8000_0000, 4'h8);
        rd(ifc_pkg::ADDR_ERRCODE);
        check(q, 32'h0000_2013);
        // Random operands, exact in every format
        for (int k = 0; k < 8; k++)
        begin
            r = $random(seed);
            w = int'($signed(r[15:0]));
            d = r >>> 8;
            tcase(ifc_pkg::OP_W2S, r, {32'h0, sgl(w)}, 4'(w == 0));
            tcase(ifc_pkg::OP_D2S, d, {32'h0, sgl(d)}, 4'(d == 0));
            tcase(ifc_pkg::OP_W2D, r, dbl(w), 4'(w == 0));
            tcase(ifc_pkg::OP_D2D, r, dbl(r), 4'(r == 0));
            tcase(ifc_pkg::OP_S2W, sgl(w), 64'(r[15:0]), 4'(w == 0));
            tcase(ifc_pkg::OP_S2D, sgl(d), {32'h0, d}, 4'(d == 0));
        end
        // Pulse mode runs once, plain mode follows the source
        wr(ifc_pkg::ADDR_SRC_LO, 32'h0000_0005);
        wr(ifc_pkg::ADDR_CTRL, 32'h0000_001A);
        wr(ifc_pkg::ADDR_SRC_LO, 32'h0000_0007);
        rd(ifc_pkg::ADDR_DST3);
        check(q, 32'h0000_4014);
        wr(ifc_pkg::ADDR_CTRL, 32'h0000_0012);
        wr(ifc_pkg::ADDR_SRC_LO, 32'h0000_0009);
        rd(ifc_pkg::ADDR_DST3);
        check(q, 32'h0000_4022);
        wr(ifc_pkg::ADDR_CTRL, 32'h0000_0000);
        // Interrupt: clear, masked event, unmask, clear again
        wr(ifc_pkg::ADDR_IRQ_STAT, 32'h0000_000F);
        tcase(ifc_pkg::OP_S2W, 32'h3F00_0000, 64'h0, 4'h3);
        check(irq, 1'b0);
        rd(ifc_pkg::ADDR_IRQ_STAT);
        check(q, 32'h0000_0003);
        wr(ifc_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
        @(posedge sys_clk);
        check(irq, 1'b1);
        wr(ifc_pkg::ADDR_IRQ_STAT, 32'h0000_0002);
        @(posedge sys_clk);
        check(irq, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
